// >>> verilog/aml_pkg.sv
// constants for the alarm mask and lane fault logic
package aml_pkg;
   localparam int ADDR_W = 10;
   localparam int DATA_W = 32;
   localparam int NUM_SRC = 6;
   localparam int NUM_LANE = 16;
   localparam int NUM_IRQ = 2;
   // register indices; byte address is four times the index
   localparam logic [ADDR_W-1:0] IDX_SUMMARY = 10'h2C0;
   localparam logic [ADDR_W-1:0] IDX_STATUS = 10'h2C1;
   localparam logic [ADDR_W-1:0] IDX_MASK = 10'h2C2;
   localparam logic [ADDR_W-1:0] IDX_LANE = 10'h2C4;
   localparam logic [ADDR_W-1:0] IDX_PIN_SEL = 10'h2C8;
   localparam logic [ADDR_W-1:0] IDX_IRQ_STATUS = 10'h2C9;
   localparam logic [ADDR_W-1:0] IDX_IRQ_MASK = 10'h2CA;
   // status and mask bit positions
   localparam int BIT_DIVIDER = 0;
   localparam int BIT_OSC = 1;
   localparam int BIT_REALIGN = 2;
   localparam int BIT_LINK = 3;
   localparam int BIT_LOCK = 4;
   localparam int BIT_FIFO = 5;
   // interrupt status bit positions
   localparam int IRQ_LANE_NEW = 0;
   localparam int IRQ_ALARM_RISE = 1;
   // reset values
   localparam logic [NUM_SRC-1:0] MASK_RST = 6'h3F;
   localparam logic [NUM_SRC-1:0] STATUS_RST = 6'h3F;
   localparam logic [NUM_LANE-1:0] LANE_RST = 16'hFFFF;
   localparam logic [NUM_IRQ-1:0] IRQ_STATUS_RST = 2'h0;
   localparam logic [NUM_IRQ-1:0] IRQ_MASK_RST = 2'h0;
   localparam logic PIN_SEL_RST = 1'b0;
   localparam logic [DATA_W-1:0] READ_NONE = 32'h0000_0000;
endpackage

// >>> verilog/aml_rst_sync.sv
// two-flop release synchroniser for the active-low reset
`timescale 1ns/1ps
module aml_rst_sync (
   input wire logic clk,
   input wire logic rst_n,
   output logic rst_sync_n
);
   logic stage1;

   // assert at once, release only after two clean edges
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1 <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         stage1 <= 1'b1;
         rst_sync_n <= stage1;
      end
   end
endmodule

// >>> verilog/aml_sticky.sv
// sticky flag bank, write one to clear, set beats clear
`timescale 1ns/1ps
module aml_sticky #(
   parameter int WIDTH = 8,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] set,
   input wire logic [WIDTH-1:0] clr,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] next_q;

   // a set in the clearing cycle must not be lost
   assign next_q = (q & ~clr) | set;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= RST_VAL;
      end else begin
         q <= next_q;
      end
   end
endmodule

// >>> verilog/aml_alarm_top.sv
// alarm gathering, lane fault flags, avalon-mm slave and interrupt
//
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ps
module aml_alarm_top (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [aml_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [aml_pkg::DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [aml_pkg::DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [aml_pkg::NUM_LANE-1:0] lane_fifo_fault,
   input wire logic lock_lost,
   input wire logic link_fault,
   input wire logic realign_event,
   input wire logic osc_phase_upset,
   input wire logic divider_mismatch,
   input wire logic cal_status,
   output logic status_output_pin,
   output logic irq
);
   import aml_pkg::*;

   logic rst_sync_n;
   logic [NUM_SRC-1:0] alarm_source_mask;
   logic [NUM_SRC-1:0] fault_status_register;
   logic [NUM_LANE-1:0] lane_fifo_fault_flags;
   logic [NUM_IRQ-1:0] irq_status;
   logic [NUM_IRQ-1:0] irq_mask;
   logic status_pin_sel;
   logic alarm_flag;
   logic next_alarm;
   logic req;
   logic wr_fire;
   logic [NUM_SRC-1:0] status_set;
   logic [NUM_SRC-1:0] status_clr;
   logic [NUM_LANE-1:0] lane_clr;
   logic [NUM_LANE-1:0] lane_be;
   logic [NUM_IRQ-1:0] irq_set;
   logic [NUM_IRQ-1:0] irq_clr;

   // register index decode, shared by writes and reads
   function automatic logic hit(input logic [ADDR_W-1:0] addr,
                                input logic [ADDR_W-1:0] idx);
      hit = (addr == idx);
   endfunction

   // pattern with only one alarm source present
   function automatic logic [NUM_SRC-1:0] lone_src(input int pos);
      lone_src = NUM_SRC'(1) << pos;
   endfunction

   // read multiplexer; unmapped indices read zero
   function automatic logic [DATA_W-1:0] read_mux(
      input logic [ADDR_W-1:0] addr,
      input logic alarm,
      input logic [NUM_SRC-1:0] status,
      input logic [NUM_SRC-1:0] mask,
      input logic [NUM_LANE-1:0] lanes,
      input logic sel,
      input logic [NUM_IRQ-1:0] ist,
      input logic [NUM_IRQ-1:0] imsk);
      read_mux = READ_NONE;
      if (hit(addr, IDX_SUMMARY)) begin
         read_mux = {{(DATA_W-1){1'b0}}, alarm};
      end else if (hit(addr, IDX_STATUS)) begin
         read_mux = {{(DATA_W-NUM_SRC){1'b0}}, status};
      end else if (hit(addr, IDX_MASK)) begin
         read_mux = {{(DATA_W-NUM_SRC){1'b0}}, mask};
      end else if (hit(addr, IDX_LANE)) begin
         read_mux = {{(DATA_W-NUM_LANE){1'b0}}, lanes};
      end else if (hit(addr, IDX_PIN_SEL)) begin
         read_mux = {{(DATA_W-1){1'b0}}, sel};
      end else if (hit(addr, IDX_IRQ_STATUS)) begin
         read_mux = {{(DATA_W-NUM_IRQ){1'b0}}, ist};
      end else if (hit(addr, IDX_IRQ_MASK)) begin
         read_mux = {{(DATA_W-NUM_IRQ){1'b0}}, imsk};
      end
   endfunction

   aml_rst_sync u_rst_sync (
      .clk(clk),
      .rst_n(rst_n),
      .rst_sync_n(rst_sync_n)
   );

   // ---------------- bus slave ----------------
   // one wait cycle for every access keeps readdata a clean flop
   assign req = avs_read | avs_write;
   assign wr_fire = avs_write & ~avs_waitrequest;

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         avs_waitrequest <= 1'b1;
      end else if (req && avs_waitrequest) begin
         avs_waitrequest <= 1'b0;
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         avs_readdata <= READ_NONE;
      end else if (avs_read && avs_waitrequest) begin
         avs_readdata <= read_mux(avs_address, alarm_flag,
            fault_status_register, alarm_source_mask,
            lane_fifo_fault_flags, status_pin_sel, irq_status, irq_mask);
      end
   end

   // ---------------- mask register ----------------
   // only six bits exist, so the reserved bits 7:6 stay zero
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         alarm_source_mask <= MASK_RST;
      end else if (wr_fire && hit(avs_address, IDX_MASK)
                   && avs_byteenable[0]) begin
         alarm_source_mask <= avs_writedata[NUM_SRC-1:0];
      end
   end

   // ---------------- alarm status ----------------
   // sources are levels: a held condition keeps its bit set
   always_comb begin
      status_set = '0;
      status_set[BIT_FIFO] = |lane_fifo_fault;
      status_set[BIT_LOCK] = lock_lost;
      status_set[BIT_LINK] = link_fault;
      status_set[BIT_REALIGN] = realign_event;
      status_set[BIT_OSC] = osc_phase_upset;
      status_set[BIT_DIVIDER] = divider_mismatch;
   end

   always_comb begin
      status_clr = '0;
      if (wr_fire && hit(avs_address, IDX_STATUS) && avs_byteenable[0]) begin
         status_clr = avs_writedata[NUM_SRC-1:0];
      end
   end

   aml_sticky #(
      .WIDTH(NUM_SRC),
      .RST_VAL(STATUS_RST)
   ) u_status (
      .clk(clk),
      .rst_n(rst_sync_n),
      .set(status_set),
      .clr(status_clr),
      .q(fault_status_register)
   );

   // ---------------- lane fault flags ----------------
   assign lane_be = {{(NUM_LANE/2){avs_byteenable[1]}},
                     {(NUM_LANE/2){avs_byteenable[0]}}};

   always_comb begin
      lane_clr = '0;
      if (wr_fire && hit(avs_address, IDX_LANE)) begin
         // ones in enabled bytes clear, zeros leave the flag alone
         lane_clr = avs_writedata[NUM_LANE-1:0] & lane_be;
      end
      if (status_clr[BIT_FIFO]) begin
         lane_clr = '1;
      end
   end

   // per-lane set enters the sticky bank and beats any clear
   aml_sticky #(
      .WIDTH(NUM_LANE),
      .RST_VAL(LANE_RST)
   ) u_lanes (
      .clk(clk),
      .rst_n(rst_sync_n),
      .set(lane_fifo_fault),
      .clr(lane_clr),
      .q(lane_fifo_fault_flags)
   );

   // ---------------- summary alarm ----------------
   // registered so the readback and the pin see the same value
   assign next_alarm =
      |(fault_status_register & ~alarm_source_mask);

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         alarm_flag <= 1'b0;
      end else begin
         alarm_flag <= next_alarm;
      end
   end

   // ---------------- status pin selector ----------------
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         status_pin_sel <= PIN_SEL_RST;
      end else if (wr_fire && hit(avs_address, IDX_PIN_SEL)
                   && avs_byteenable[0]) begin
         status_pin_sel <= avs_writedata[0];
      end
   end

   // with the selector set the pin lags the summary flag by one cycle, otherwise it follows cal_status
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         status_output_pin <= 1'b0;
      end else if (status_pin_sel) begin
         status_output_pin <= alarm_flag;
      end else begin
         status_output_pin <= cal_status;
      end
   end

   // ---------------- interrupt ----------------
   always_comb begin
      irq_set = '0;
      irq_set[IRQ_LANE_NEW] = |(lane_fifo_fault & ~lane_fifo_fault_flags);
      irq_set[IRQ_ALARM_RISE] = next_alarm & ~alarm_flag;
   end

   always_comb begin
      irq_clr = '0;
      if (wr_fire && hit(avs_address, IDX_IRQ_STATUS)
          && avs_byteenable[0]) begin
         irq_clr = avs_writedata[NUM_IRQ-1:0];
      end
   end

   aml_sticky #(
      .WIDTH(NUM_IRQ),
      .RST_VAL(IRQ_STATUS_RST)
   ) u_irq (
      .clk(clk),
      .rst_n(rst_sync_n),
      .set(irq_set),
      .clr(irq_clr),
      .q(irq_status)
   );

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         irq_mask <= IRQ_MASK_RST;
      end else if (wr_fire && hit(avs_address, IDX_IRQ_MASK)
                   && avs_byteenable[0]) begin
         irq_mask <= avs_writedata[NUM_IRQ-1:0];
      end
   end

   // a mask bit of one lets the event through
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status & irq_mask);
      end
   end

   // ---------------- checks ----------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_sync_n);

   sequence lane_write_s;
      wr_fire && hit(avs_address, IDX_LANE);
   endsequence

   sequence bulk_clear_s;
      wr_fire && hit(avs_address, IDX_STATUS) && avs_byteenable[0]
         && avs_writedata[BIT_FIFO];
   endsequence

   sequence quiet_lanes_s;
      lane_fifo_fault == '0;
   endsequence

   mask_fifo_a: assert property (
      fault_status_register == lone_src(BIT_FIFO)
      && alarm_source_mask[BIT_FIFO] |=> !alarm_flag)
      else $error("masked fifo fault reached summary");

   mask_lock_a: assert property (
      fault_status_register == lone_src(BIT_LOCK)
      && alarm_source_mask[BIT_LOCK] |=> !alarm_flag)
      else $error("masked lock loss reached summary");

   mask_link_a: assert property (
      fault_status_register == lone_src(BIT_LINK)
      && alarm_source_mask[BIT_LINK] |=> !alarm_flag)
      else $error("masked link fault reached summary");

   mask_realign_a: assert property (
      fault_status_register == lone_src(BIT_REALIGN)
      && alarm_source_mask[BIT_REALIGN] |=> !alarm_flag)
      else $error("masked realign reached summary");

   mask_osc_a: assert property (
      fault_status_register == lone_src(BIT_OSC)
      && alarm_source_mask[BIT_OSC] |=> !alarm_flag)
      else $error("masked phase upset reached summary");

   mask_divider_a: assert property (
      fault_status_register == lone_src(BIT_DIVIDER)
      && alarm_source_mask[BIT_DIVIDER] |=> !alarm_flag)
      else $error("masked divider mismatch reached summary");

   reset_values_a: assert property (
      $rose(rst_sync_n) |-> alarm_source_mask == MASK_RST
      && lane_fifo_fault_flags == LANE_RST
      && fault_status_register == STATUS_RST)
      else $error("register reset value wrong");

   lane_set_a: assert property (
      lane_fifo_fault != '0 |=>
      (lane_fifo_fault_flags & $past(lane_fifo_fault))
      == $past(lane_fifo_fault))
      else $error("lane fault did not set its flag");

   lane_clear_a: assert property (
      lane_write_s and quiet_lanes_s and !status_clr[BIT_FIFO] |=>
      lane_fifo_fault_flags == ($past(lane_fifo_fault_flags)
      & ~($past(avs_writedata[NUM_LANE-1:0]) & $past(lane_be))))
      else $error("lane flag write-one-clear wrong");

   bulk_clear_a: assert property (
      bulk_clear_s and quiet_lanes_s |=> lane_fifo_fault_flags == '0
      ##1 (lane_fifo_fault_flags == '0 || $past(lane_fifo_fault) != '0))
      else $error("fifo status clear left lane flags");

   summary_a: assert property (
      ##1 alarm_flag ==
      $past(|(fault_status_register & ~alarm_source_mask)))
      else $error("summary alarm disagrees with status");

   fifo_status_a: assert property (
      |lane_fifo_fault ##1 1'b1 |-> fault_status_register[BIT_FIFO])
      else $error("lane fault did not set fifo status");

   pin_route_a: assert property (
      status_pin_sel ##1 status_pin_sel |-> status_output_pin
      == $past(alarm_flag))
      else $error("status pin does not follow summary");

   bus_ack_a: assert property (
      req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer not one cycle");
endmodule

// >>> testbench/tb.sv
// self-checking bench for the alarm mask and lane fault logic
`timescale 1ns/1ps
module tb;
   import aml_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [ADDR_W-1:0] avs_address = '0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [DATA_W-1:0] avs_writedata = '0;
   logic [3:0] avs_byteenable = 4'hF;
   logic [DATA_W-1:0] avs_readdata;
   logic avs_waitrequest;
   logic [NUM_LANE-1:0] lane_fifo_fault = '0;
   logic [NUM_SRC-1:0] src = '0;
   logic cal_status = 1'b0;
   logic status_output_pin;
   logic irq;
   int n_mismatch = 0;
   int checks_done = 0;
   int cycles = 0;
   logic [NUM_SRC-1:0] msk;
   logic [NUM_SRC-1:0] one;
   logic [NUM_LANE-1:0] pat;
   logic [NUM_LANE-1:0] wv;

   aml_alarm_top aml_alarm_top_i (
      .clk(clk),
      .rst_n(rst_n),
      .avs_address(avs_address),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .lane_fifo_fault(lane_fifo_fault),
      .lock_lost(src[BIT_LOCK]),
      .link_fault(src[BIT_LINK]),
      .realign_event(src[BIT_REALIGN]),
      .osc_phase_upset(src[BIT_OSC]),
      .divider_mismatch(src[BIT_DIVIDER]),
      .cal_status(cal_status),
      .status_output_pin(status_output_pin),
      .irq(irq)
   );

   always #5 clk = ~clk;

   function automatic logic alarm_exp(input logic [NUM_SRC-1:0] st,
                                      input logic [NUM_SRC-1:0] m);
      return |(st & ~m);
   endfunction

   function automatic logic [NUM_LANE-1:0] lane_exp(
         input logic [NUM_LANE-1:0] f, input logic [NUM_LANE-1:0] w,
         input logic [NUM_LANE-1:0] hold);
      return (f & ~w) | hold;
   endfunction

   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // a hung handshake ends here rather than spinning forever
   always @(posedge clk) begin
      cycles++;
      if (cycles == 6000) begin
         n_mismatch++;
         complete_run();
      end
   end

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one avalon access; the extra edge keeps back-to-back calls apart
   task automatic bus(input logic wr_en, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d,
                      output logic [DATA_W-1:0] q);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr_en;
      avs_read <= ~wr_en;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      logic [DATA_W-1:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rdchk(input string what, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] exp);
      logic [DATA_W-1:0] q;
      bus(1'b0, a, '0, q);
      check(what, q, exp);
   endtask

   task automatic clear_all;
      wr(IDX_STATUS, 32'h0000_003F);
      wr(IDX_LANE, 32'h0000_FFFF);
      wr(IDX_IRQ_STATUS, 32'h0000_0003);
   endtask

   initial begin
      void'($urandom(69));
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      rdchk("mask", IDX_MASK, 32'h0000_003F);
      rdchk("lanes", IDX_LANE, 32'h0000_FFFF);
      rdchk("status", IDX_STATUS, 32'h0000_003F);
      rdchk("summary", IDX_SUMMARY, 32'h0);
      rdchk("unmapped", 10'h2C3, 32'h0);
      wr(IDX_MASK, 32'h0000_00FF);
      rdchk("mask reserved", IDX_MASK, 32'h0000_003F);
      $display("test reset done");

      clear_all();
      rdchk("status clear", IDX_STATUS, 32'h0);
      rdchk("lanes clear", IDX_LANE, 32'h0);
      wr(IDX_PIN_SEL, 32'h1);
      // every source under a random mask, then with its own bit flipped
      for (int b = 0; b < NUM_SRC; b++) begin
         one = 6'h01 << b;
         msk = NUM_SRC'($urandom);
         wr(IDX_MASK, {26'h0, msk});
         if (b == BIT_FIFO) begin
            lane_fifo_fault <= 16'($urandom) | 16'h0001;
         end else begin
            src[b] <= 1'b1;
         end
         @(posedge clk);
         lane_fifo_fault <= '0;
         src <= '0;
         repeat (3) @(posedge clk);
         rdchk("status src", IDX_STATUS, {26'h0, one});
         repeat (2) begin
            rdchk("summary", IDX_SUMMARY,
                  {31'h0, alarm_exp(one, msk)});
            check("pin", {31'h0, status_output_pin},
                  {31'h0, alarm_exp(one, msk)});
            msk = msk ^ one;
            wr(IDX_MASK, {26'h0, msk});
         end
         clear_all();
      end
      $display("test mask done");

      repeat (4) begin
         pat = 16'($urandom);
         lane_fifo_fault <= pat;
         @(posedge clk);
         lane_fifo_fault <= '0;
         repeat (2) @(posedge clk);
         rdchk("lanes set", IDX_LANE, {16'h0, pat});
         wv = 16'($urandom);
         wr(IDX_LANE, {16'h0, wv});
         rdchk("lanes w1c", IDX_LANE,
               {16'h0, lane_exp(pat, wv, '0)});
         lane_fifo_fault <= 16'h8001;
         wr(IDX_LANE, 32'h0000_FFFF);
         rdchk("lanes held", IDX_LANE,
               {16'h0, lane_exp(16'hFFFF, 16'hFFFF, 16'h8001)});
         lane_fifo_fault <= '0;
         wr(IDX_LANE, 32'h0000_0000);
         rdchk("lanes zero write", IDX_LANE, 32'h0000_8001);
         wr(IDX_STATUS, 32'h0000_0020);
         rdchk("lanes by status", IDX_LANE, 32'h0);
      end
      // high byte disabled: upper lane flags must survive the clear
      lane_fifo_fault <= 16'hFFFF;
      @(posedge clk);
      lane_fifo_fault <= '0;
      avs_byteenable <= 4'h1;
      wr(IDX_LANE, 32'h0000_FFFF);
      avs_byteenable <= 4'hF;
      rdchk("lanes byte enable", IDX_LANE, 32'h0000_FF00);
      $display("test lanes done");

      clear_all();
      wr(IDX_MASK, 32'h0);
      wr(IDX_IRQ_MASK, 32'h2);
      src[BIT_LOCK] <= 1'b1;
      @(posedge clk);
      src <= '0;
      repeat (4) @(posedge clk);
      check("irq raised", {31'h0, irq}, 32'h1);
      rdchk("irq status", IDX_IRQ_STATUS, 32'h2);
      wr(IDX_IRQ_MASK, 32'h0);
      repeat (2) @(posedge clk);
      check("irq masked", {31'h0, irq}, 32'h0);
      wr(IDX_IRQ_MASK, 32'h2);
      repeat (2) @(posedge clk);
      check("irq unmasked", {31'h0, irq}, 32'h1);
      wr(IDX_IRQ_STATUS, 32'h2);
      repeat (2) @(posedge clk);
      check("irq cleared", {31'h0, irq}, 32'h0);
      $display("test irq done");

      wr(IDX_PIN_SEL, 32'h0);
      cal_status <= 1'b1;
      repeat (3) @(posedge clk);
      check("pin cal high", {31'h0, status_output_pin}, 32'h1);
      cal_status <= 1'b0;
      repeat (3) @(posedge clk);
      check("pin cal low", {31'h0, status_output_pin}, 32'h0);
      $display("test pin select done");
      complete_run();
   end
endmodule
